// [include/ldsd_pkg.sv]
package ldsd_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [14:0] LOCK_CTRL_ADDR = 15'h0028;
  localparam logic [14:0] BLEED_SEL_ADDR = 15'h002a;
  localparam logic [14:0] MOD_CTRL_ADDR = 15'h002b;
  localparam logic [14:0] INT_WORD_ADDR = 15'h0010;
  localparam logic [7:0] LOCK_CTRL_RESET = 8'h03;
  localparam logic [7:0] BLEED_SEL_RESET = 8'h00;
  localparam logic [7:0] MOD_CTRL_RESET = 8'h01;
  localparam logic [7:0] LOCK_CTRL_MASK = 8'h07;
  localparam logic [7:0] BLEED_SEL_MASK = 8'h29;
  localparam logic [7:0] MOD_CTRL_MASK = 8'h35;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int REFERENCE_LOSS_UNLOCK_EN_BIT = 0;
  localparam int LCOUNT_LSB = 1;
  localparam int READ_SEL_BIT = 0;
  localparam int LATCH_SEL_BIT = 3;
  localparam int BLEED_POLARITY_BIT = 5;
  localparam int MOD_DIS_BIT = 0;
  localparam int RST_MASK_BIT = 2;
  localparam int AUX_EN_BIT = 4;
  localparam int HALF_LSB_BIT = 5;
  // ---------------------------------------------------------------
  // serial frame and lock counting
  // ---------------------------------------------------------------
  localparam logic [4:0] FRAME_LAST_BIT = 5'd23;
  localparam logic [4:0] ADDR_LAST_BIT = 5'd15;
  localparam logic [13:0] LOCK_BASE_CYCLES = 14'd1024;
endpackage : ldsd_pkg

// [src/ldsd_top.sv]
`timescale 1ns/1ps
module ldsd_top
  import ldsd_pkg::*;
#(
  parameter logic [13:0] LOCK_BASE = LOCK_BASE_CYCLES
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe_n,
  input wire logic pfd_tick,
  input wire logic pfd_in_window,
  input wire logic ref_present,
  input wire logic [1:0] lock_window_bias,
  input wire logic lock_precision_sel,
  output logic lock_detect,
  output logic [2:0] lock_window_code,
  output logic bleed_polarity,
  output logic latch_enable_choice,
  output logic readback_version_sel,
  output logic half_lsb_eff,
  output logic aux_modulator_en,
  output logic modulator_disable,
  output logic modulator_reset
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] sclk_sync_reg;
  logic [1:0] cs_sync_reg;
  logic [1:0] sdio_sync_reg;
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      sclk_sync_reg <= 3'h0;
      cs_sync_reg <= 2'h3;
      sdio_sync_reg <= 2'h0;
    end
    else
    begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], sclk};
      cs_sync_reg <= {cs_sync_reg[0], cs_n};
      sdio_sync_reg <= {sdio_sync_reg[0], sdio_in};
    end
  end
  wire logic cs_idle = cs_sync_reg[1];
  wire logic sdio_s = sdio_sync_reg[1];
  wire logic sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
  wire logic sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
  // ---------------------------------------------------------------
  // serial frame: read flag, 15-bit address, 8 data bits, msb first
  // ---------------------------------------------------------------
  logic [22:0] shift_reg;
  logic [4:0] bit_cnt_reg;
  logic [7:0] rd_shift_reg;
  logic rd_active_reg;
  logic [7:0] lock_reg;
  logic [7:0] bleed_reg;
  logic [7:0] mod_reg;
  wire logic frame_rise = sclk_rise & ~cs_idle;
  wire logic is_read = shift_reg[14];
  wire logic [14:0] rd_addr = {shift_reg[13:0], sdio_s};
  wire logic [14:0] wr_addr = shift_reg[21:7];
  wire logic [7:0] wr_data = {shift_reg[6:0], sdio_s};
  wire logic rd_load = frame_rise & (bit_cnt_reg == ADDR_LAST_BIT) & is_read;
  wire logic wr_commit = frame_rise & (bit_cnt_reg == FRAME_LAST_BIT) & ~shift_reg[22];
  wire logic [7:0] rd_value =
    (rd_addr == LOCK_CTRL_ADDR) ? lock_reg :
    (rd_addr == BLEED_SEL_ADDR) ? bleed_reg :
    (rd_addr == MOD_CTRL_ADDR) ? mod_reg : 8'h00;
  always_ff @(posedge clk_sys)
  begin
    if (srst || cs_idle)
    begin
      shift_reg <= 23'h0;
      bit_cnt_reg <= 5'h0;
    end
    else if (sclk_rise)
    begin
      shift_reg <= {shift_reg[21:0], sdio_s};
      bit_cnt_reg <= bit_cnt_reg + 5'd1;
    end
  end
  // readback drives on falling edges so the host samples on rising
  always_ff @(posedge clk_sys)
  begin
    if (srst || cs_idle)
    begin
      rd_shift_reg <= 8'h00;
      rd_active_reg <= 1'b0;
      sdio_out <= 1'b0;
      sdio_oe_n <= 1'b1;
    end
    else if (rd_load)
    begin
      rd_shift_reg <= rd_value;
      rd_active_reg <= 1'b1;
    end
    else if (sclk_fall && rd_active_reg)
    begin
      sdio_out <= rd_shift_reg[7];
      sdio_oe_n <= 1'b0;
      rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
    end
  end
  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  wire logic [7:0] lock_next = (wr_commit && wr_addr == LOCK_CTRL_ADDR) ?
    (wr_data & LOCK_CTRL_MASK) : lock_reg;
  wire logic [7:0] bleed_next = (wr_commit && wr_addr == BLEED_SEL_ADDR) ?
    (wr_data & BLEED_SEL_MASK) : bleed_reg;
  wire logic [7:0] mod_next = (wr_commit && wr_addr == MOD_CTRL_ADDR) ?
    (wr_data & MOD_CTRL_MASK) : mod_reg;
  wire logic int_word_write = wr_commit && (wr_addr == INT_WORD_ADDR);
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      lock_reg <= LOCK_CTRL_RESET;
      bleed_reg <= BLEED_SEL_RESET;
      mod_reg <= MOD_CTRL_RESET;
    end
    else
    begin
      lock_reg <= lock_next;
      bleed_reg <= bleed_next;
      mod_reg <= mod_next;
    end
  end
  // ---------------------------------------------------------------
  // decoded controls
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      bleed_polarity <= 1'b0;
      latch_enable_choice <= 1'b0;
      readback_version_sel <= 1'b0;
      half_lsb_eff <= 1'b0;
      aux_modulator_en <= 1'b0;
      modulator_disable <= 1'b1;
      modulator_reset <= 1'b0;
      lock_window_code <= 3'h0;
    end
    else
    begin
      bleed_polarity <= bleed_reg[BLEED_POLARITY_BIT];
      latch_enable_choice <= bleed_reg[LATCH_SEL_BIT];
      readback_version_sel <= bleed_reg[READ_SEL_BIT];
      half_lsb_eff <= mod_reg[HALF_LSB_BIT] & ~mod_reg[AUX_EN_BIT];
      aux_modulator_en <= mod_reg[AUX_EN_BIT];
      modulator_disable <= mod_reg[MOD_DIS_BIT];
      modulator_reset <= int_word_write & ~mod_reg[RST_MASK_BIT];
      lock_window_code <= {lock_window_bias, lock_precision_sel};
    end
  end
  // ---------------------------------------------------------------
  // digital lock detector
  // ---------------------------------------------------------------
  logic [13:0] lock_cnt_reg;
  wire logic [1:0] count_sel = lock_reg[LCOUNT_LSB +: 2];
  wire logic [13:0] lock_thresh = LOCK_BASE << count_sel;
  wire logic ref_lost = ~ref_present;
  wire logic lol_clear = ref_lost & lock_reg[REFERENCE_LOSS_UNLOCK_EN_BIT];
  wire logic cnt_done = (lock_cnt_reg + 14'd1) >= lock_thresh;
  always_ff @(posedge clk_sys)
  begin
    if (srst || lol_clear)
    begin
      lock_cnt_reg <= 14'h0;
      lock_detect <= 1'b0;
    end
    else if (pfd_tick && !ref_lost)
    begin
      if (!pfd_in_window)
      begin
        lock_cnt_reg <= 14'h0;
        lock_detect <= 1'b0;
      end
      else if (cnt_done)
      begin
        lock_cnt_reg <= lock_thresh;
        lock_detect <= 1'b1;
      end
      else
      begin
        lock_cnt_reg <= lock_cnt_reg + 14'd1;
      end
    end
  end
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  lock_rise_count_a: assert property (@(posedge clk_sys) disable iff (srst)
    $rose(lock_detect) |-> $past(pfd_tick) && $past(pfd_in_window) && $past(cnt_done))
    else $error("lock rose before count reached");
  lock_window_drop_a: assert property (@(posedge clk_sys) disable iff (srst)
    pfd_tick && !pfd_in_window && ref_present |=> !lock_detect && lock_cnt_reg == 14'h0)
    else $error("lock held after out-of-window cycle");
  ref_loss_drop_a: assert property (@(posedge clk_sys) disable iff (srst)
    ref_lost && lock_reg[REFERENCE_LOSS_UNLOCK_EN_BIT] |=> !lock_detect)
    else $error("lock kept after reference loss");
  ref_loss_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
    ref_lost && !lock_reg[REFERENCE_LOSS_UNLOCK_EN_BIT] |=> lock_detect == $past(lock_detect))
    else $error("lock changed with loss detection off");
  bleed_polarity_out_a: assert property (@(posedge clk_sys) disable iff (srst)
    wr_commit && wr_addr == BLEED_SEL_ADDR |=> ##1 bleed_polarity == $past(wr_data[5], 2))
    else $error("bleed polarity not following write");
  half_lsb_gate_a: assert property (@(posedge clk_sys) disable iff (srst)
    mod_reg[HALF_LSB_BIT] |=> half_lsb_eff == !$past(mod_reg[AUX_EN_BIT]))
    else $error("half lsb active with aux modulator on");
  int_reset_mask_a: assert property (@(posedge clk_sys) disable iff (srst)
    int_word_write |=> modulator_reset == !$past(mod_reg[RST_MASK_BIT]))
    else $error("modulator reset pulse wrong");
  reserved_zero_a: assert property (@(posedge clk_sys) disable iff (srst)
    (lock_reg & ~LOCK_CTRL_MASK) == 8'h00 && (mod_reg & ~MOD_CTRL_MASK) == 8'h00 &&
    (bleed_reg & ~BLEED_SEL_MASK) == 8'h00)
    else $error("reserved bit set");
  reset_default_a: assert property (@(posedge clk_sys)
    srst |=> lock_reg == LOCK_CTRL_RESET && mod_reg == MOD_CTRL_RESET && modulator_disable)
    else $error("wrong default after reset");
  readback_src_a: assert property (@(posedge clk_sys) disable iff (srst)
    rd_load |=> rd_shift_reg == $past(rd_value))
    else $error("readback word not loaded");
endmodule : ldsd_top

// [testbench/ldsd_host_model.sv]
`timescale 1ns/1ps
module ldsd_host_model (
  input wire logic clk_sys,
  input wire logic sdio_out,
  input wire logic sdio_oe_n,
  output logic sclk,
  output logic cs_n,
  output logic sdio_in
);
  // ---------------------------------------------------------------
  // three-wire host, six clocks per serial phase
  // ---------------------------------------------------------------
  localparam int HALF = 6;
  logic drv;
  // shared wire: device wins while its enable is low
  assign sdio_in = (sdio_oe_n === 1'b0) ? sdio_out : drv;
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    drv = 1'b0;
  end
  task automatic xfer(input logic rw, input logic [14:0] addr, input logic [7:0] wdata,
    output logic [7:0] rdata);
    logic [23:0] word;
    word = {rw, addr, wdata};
    rdata = 8'h00;
    @(posedge clk_sys);
    cs_n <= 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      sclk <= 1'b0;
      // released during read data: toggle so a stale value never matches
      drv <= (rw && i < 8) ? ~drv : word[i];
      repeat (HALF) @(posedge clk_sys);
      if (i < 8)
        rdata = {rdata[6:0], sdio_in};
      sclk <= 1'b1;
      repeat (HALF) @(posedge clk_sys);
    end
    cs_n <= 1'b1;
    drv <= ~word[0];
    repeat (HALF) @(posedge clk_sys);
    sclk <= 1'b0;
    repeat (HALF) @(posedge clk_sys);
  endtask : xfer
endmodule : ldsd_host_model

// [testbench/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import ldsd_pkg::*;
  localparam logic [13:0] BASE = 14'h0004;
  localparam int A_LCK = 32'h28;
  localparam int A_BLD = 32'h2a;
  localparam int A_MOD = 32'h2b;
  logic clk_sys, srst, sclk, cs_n, sdio_in, sdio_out, sdio_oe_n;
  logic pfd_tick, pfd_in_window, ref_present, lock_precision_sel, lock_detect;
  logic bleed_polarity, latch_enable_choice, readback_version_sel, half_lsb_eff;
  logic aux_modulator_en, modulator_disable, modulator_reset;
  logic [1:0] lock_window_bias;
  logic [2:0] lock_window_code;
  logic [7:0] rd;
  int miscompares = 0;
  int samples_checked = 0;
  int pulses = 0;
  int mdl[int];
  int msk[int];
  ldsd_top #(.LOCK_BASE(BASE)) ldsd_top_inst (.clk_sys(clk_sys), .srst(srst), .sclk(sclk),
    .cs_n(cs_n), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
    .pfd_tick(pfd_tick), .pfd_in_window(pfd_in_window), .ref_present(ref_present),
    .lock_window_bias(lock_window_bias), .lock_precision_sel(lock_precision_sel),
    .lock_detect(lock_detect), .lock_window_code(lock_window_code),
    .bleed_polarity(bleed_polarity), .latch_enable_choice(latch_enable_choice),
    .readback_version_sel(readback_version_sel), .half_lsb_eff(half_lsb_eff),
    .aux_modulator_en(aux_modulator_en), .modulator_disable(modulator_disable),
    .modulator_reset(modulator_reset));
  ldsd_host_model ldsd_host_model_inst (.clk_sys(clk_sys), .sdio_out(sdio_out),
    .sdio_oe_n(sdio_oe_n), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in));
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // sample mid-cycle so the registered pulse is settled
  always @(negedge clk_sys)
    if (modulator_reset === 1'b1)
      pulses++;
  // ---------------------------------------------------------------
  // checks, register model, stimulus helpers
  // ---------------------------------------------------------------
  task automatic complete_run();
    $display("samples_checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wr(input int a, input int d);
    logic [7:0] x;
    ldsd_host_model_inst.xfer(1'b0, a[14:0], d[7:0], x);
    if (mdl.exists(a))
      mdl[a] = d & msk[a];
  endtask : wr
  task automatic rdchk(input int a);
    ldsd_host_model_inst.xfer(1'b1, a[14:0], 8'h00, rd);
    check("readback", mdl.exists(a) ? mdl[a][7:0] : 8'h00, rd);
  endtask : rdchk
  task automatic outs();
    repeat (3) @(posedge clk_sys);
    #1;
    check("bleed_polarity", mdl[A_BLD][5], bleed_polarity);
    check("latch_choice", mdl[A_BLD][3], latch_enable_choice);
    check("readback_sel", mdl[A_BLD][0], readback_version_sel);
    check("half_lsb", mdl[A_MOD][5] & !mdl[A_MOD][4], half_lsb_eff);
    check("aux_en", mdl[A_MOD][4], aux_modulator_en);
    check("mod_disable", mdl[A_MOD][0], modulator_disable);
    check("window", {lock_window_bias, lock_precision_sel}, lock_window_code);
  endtask : outs
  task automatic ticks(input int n, input logic win);
    @(posedge clk_sys);
    pfd_tick <= 1'b1;
    pfd_in_window <= win;
    repeat (n) @(posedge clk_sys);
    pfd_tick <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : ticks
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    miscompares++;
    complete_run();
  end
  initial
  begin
    int v;
    int p0;
    srst = 1'b1;
    pfd_tick = 1'b0;
    pfd_in_window = 1'b0;
    ref_present = 1'b1;
    lock_window_bias = 2'h0;
    lock_precision_sel = 1'b0;
    mdl[A_LCK] = 32'h03;
    mdl[A_BLD] = 32'h00;
    mdl[A_MOD] = 32'h01;
    msk[A_LCK] = 32'h07;
    msk[A_BLD] = 32'h29;
    msk[A_MOD] = 32'h35;
    v = $urandom(66441);
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    foreach (mdl[a]) rdchk(a);
    rdchk(32'h29);
    outs();
    wr(A_BLD, 32'hff);
    wr(A_MOD, 32'h20);
    outs();
    repeat (6)
    begin
      v = $urandom;
      wr(A_LCK, v >> 24);
      wr(A_BLD, v);
      wr(A_MOD, v >> 8);
      lock_window_bias <= v[17:16];
      lock_precision_sel <= v[18];
      foreach (mdl[a]) rdchk(a);
      outs();
    end
    for (int m = 0; m < 2; m++)
    begin
      wr(A_MOD, m << 2);
      p0 = pulses;
      wr(32'h10, $urandom);
      repeat (4) @(posedge clk_sys);
      check("sd_reset_pulses", 1 - m, pulses - p0);
    end
    for (int s = 0; s < 4; s++)
    begin
      wr(A_LCK, s * 2 + 1);
      ticks(1, 1'b0);
      ticks((4 << s) - 1, 1'b1);
      check("lock_early", 8'h00, lock_detect);
      ticks(1, 1'b1);
      check("lock", 8'h01, lock_detect);
    end
    for (int e = 0; e < 2; e++)
    begin
      wr(A_LCK, e);
      ticks(4, 1'b1);
      @(posedge clk_sys);
      ref_present <= 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
      check("lock_ref_loss", 1 - e, lock_detect);
      @(posedge clk_sys);
      ref_present <= 1'b1;
    end
    complete_run();
  end
endmodule : testbench
